// ===== mmc_dev.sv
`timescale 1ns/1ps
// Purpose: Device end: register bank, speed mapping and output voltage command.
// Assumes: Host sends a command byte, and for writes two data bytes.
// Notes:   Unknown commands are ignored; reads answer two bytes.
module mmc_dev
(
	input  wire logic        clk_sys,       // System clock.
	input  wire logic        rstn,          // Asynchronous reset, active low.
	mmc_link_if.dev          link,          // Byte link to the host.
	input  wire logic [11:0] supply_adc,    // Supply voltage conversion.
	input  wire logic [11:0] speed_adc,     // Speed input conversion.
	input  wire logic [11:0] current_adc,   // Load current conversion.
	input  wire logic        pwm_in,        // PWM/brake input level.
	input  wire logic [11:0] speed_reg,     // Serial speed setting.
	input  wire logic [11:0] pot_ceiling,   // Onboard potentiometer for the ceiling.
	input  wire logic        pot_moved,     // Pulse: potentiometer changed.
	input  wire logic        speed_lock_bit, // Speed input no longer steers output.
	input  wire logic        ceil_lock,     // Ceiling guarded from the potentiometer.
	input  wire logic        supply_comp_en, // Supply compensation enable.
	input  wire logic        mode_sw1,      // Mode switch one.
	input  wire logic        mode_sw2,      // Mode switch two.
	output logic      [11:0] out_voltage_r  // Output voltage command.
);
	// ************************************************************
	// Storage
	// ************************************************************
	logic [13:0] ircomp_r;   // Resistance-drop compensation.
	logic [11:0] ceil_r;     // Output voltage ceiling.
	logic [11:0] low_r;      // Speed input low level.
	logic [11:0] high_r;     // Speed input high level.
	logic [11:0] low_act_r;  // Low level in force since restart.
	logic [11:0] high_act_r; // High level in force since restart.
	logic        map_en_r;   // Mapping enabled by switches at restart.
	logic        boot_r;     // High once the first cycle after reset passed.
	logic [13:0] period_w;   // Measured period.
	logic [13:0] width_w;    // Measured width.
	mmc_pkg::mmc_dev_st_t st_r; // Command parse state.
	logic [7:0]  cmd_r;      // Command in progress.
	logic [6:0]  hi_r;       // First data byte of a write.
	logic [13:0] rd_r;       // Value being answered.
	logic        rd_lo_r;    // Second answer byte still to send.
	logic [7:0]  d2h_byte_r; // Answer byte.
	logic        d2h_vld_r;  // Answer strobe.

	mmc_pulse_meas u_meas
	(
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.pwm_in   (pwm_in),
		.period_r (period_w),
		.width_r  (width_w)
	);

	// ************************************************************
	// Command decode
	// ************************************************************
	wire        byte_in = link.h2d_valid;
	wire [7:0]  b_in    = link.h2d_byte;
	wire        is_wr   = (b_in == mmc_pkg::CMD_WR_IRCOMP) || (b_in == mmc_pkg::CMD_WR_CEIL)
	                   || (b_in == mmc_pkg::CMD_WR_LOW) || (b_in == mmc_pkg::CMD_WR_HIGH);
	logic [13:0] rd_val;     // Read mux result.
	logic        rd_hit;     // Command is a known read.

	// Read mux; narrower values sit in the low bits.
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (b_in)
			mmc_pkg::CMD_RD_SUPPLY:  rd_val = {2'b00, supply_adc};
			mmc_pkg::CMD_RD_SPEED:   rd_val = {2'b00, speed_adc};
			mmc_pkg::CMD_RD_CURRENT: rd_val = {2'b00, current_adc};
			mmc_pkg::CMD_RD_PERIOD:  rd_val = period_w;
			mmc_pkg::CMD_RD_WIDTH:   rd_val = width_w;
			mmc_pkg::CMD_RD_IRCOMP:  rd_val = ircomp_r;
			mmc_pkg::CMD_RD_CEIL:    rd_val = {2'b00, ceil_r};
			mmc_pkg::CMD_RD_LOW:     rd_val = {2'b00, low_r};
			mmc_pkg::CMD_RD_HIGH:    rd_val = {2'b00, high_r};
			default:
			begin
				rd_val = 14'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	wire [13:0] wr_val   = {hi_r, b_in[6:0]};
	wire        wr_done  = (st_r == mmc_pkg::MMC_LO) && byte_in;
	wire        wr_ceil  = wr_done && (cmd_r == mmc_pkg::CMD_WR_CEIL);

	// ************************************************************
	// Parser and answer
	// ************************************************************
	// A new command during an answer is accepted; a new read replaces the answer's pending second byte.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r       <= mmc_pkg::MMC_IDLE;
			cmd_r      <= 8'h00;
			hi_r       <= 7'h00;
			rd_r       <= 14'h0000;
			rd_lo_r    <= 1'b0;
			d2h_byte_r <= 8'h00;
			d2h_vld_r  <= 1'b0;
		end
		else
		begin
			d2h_vld_r <= 1'b0;
			if (rd_lo_r)
			begin
				d2h_byte_r <= {1'b0, rd_r[mmc_pkg::HI_LSB-1:0]};
				d2h_vld_r  <= 1'b1;
				rd_lo_r    <= 1'b0;
			end
			unique case (st_r)
				mmc_pkg::MMC_IDLE:
					if (byte_in && is_wr)
					begin
						cmd_r <= b_in;
						st_r  <= mmc_pkg::MMC_HI;
					end
					else if (byte_in && rd_hit)
					begin
						d2h_byte_r <= {1'b0, rd_val[13:mmc_pkg::HI_LSB]};
						d2h_vld_r  <= 1'b1;
						rd_r       <= rd_val;
						rd_lo_r    <= 1'b1;
					end
				mmc_pkg::MMC_HI:
					if (byte_in)
					begin
						hi_r <= b_in[6:0];
						st_r <= mmc_pkg::MMC_LO;
					end
				mmc_pkg::MMC_LO:
					if (byte_in)
						st_r <= mmc_pkg::MMC_IDLE;
				default:
					st_r <= mmc_pkg::MMC_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Tuning registers
	// ************************************************************
	// A serial write always lands; the potentiometer only when unlocked.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ircomp_r <= mmc_pkg::RST_IRCOMP;
			ceil_r   <= mmc_pkg::RST_CEIL;
			low_r    <= mmc_pkg::RST_LOW;
			high_r   <= mmc_pkg::RST_HIGH;
		end
		else
		begin
			if (wr_done && cmd_r == mmc_pkg::CMD_WR_IRCOMP)
				ircomp_r <= wr_val;
			if (wr_ceil)
				ceil_r <= wr_val[11:0];
			else if (pot_moved && !ceil_lock)
				ceil_r <= pot_ceiling;
			if (wr_done && cmd_r == mmc_pkg::CMD_WR_LOW)
				low_r <= wr_val[11:0];
			if (wr_done && cmd_r == mmc_pkg::CMD_WR_HIGH)
				high_r <= wr_val[11:0];
		end
	end

	// Levels in force are caught only once after restart, standing in for a flash reload.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			boot_r     <= 1'b0;
			map_en_r   <= 1'b0;
			low_act_r  <= mmc_pkg::RST_LOW;
			high_act_r <= mmc_pkg::RST_HIGH;
		end
		else if (!boot_r)
		begin
			boot_r     <= 1'b1;
			map_en_r   <= !mode_sw1 && !mode_sw2;
			low_act_r  <= low_r;
			high_act_r <= high_r;
		end
	end

	// ************************************************************
	// Output voltage path
	// ************************************************************
	// Linear map of speed input from low level (0%) to high level (100%).
	wire [11:0] span    = (high_act_r > low_act_r) ? high_act_r - low_act_r : 12'h001;
	wire [11:0] above   = (speed_adc > low_act_r) ? speed_adc - low_act_r : 12'h000;
	wire [23:0] scaled  = {above, 12'h000} / {12'h000, span};
	wire [11:0] mapped  = (scaled > 24'h000FFF) ? 12'hFFF : scaled[11:0];
	wire [11:0] raw_sp  = map_en_r ? mapped : speed_adc;
	wire [11:0] demand  = speed_lock_bit ? speed_reg : raw_sp;
	// Supply compensation scales demand against the ceiling as a full-scale reference.
	wire [23:0] ref_sc  = demand * ceil_r;
	wire [11:0] base    = supply_comp_en ? ref_sc[23:12] : demand;
	wire [25:0] ir_prod = ircomp_r * current_adc;
	wire [12:0] ir_add  = ir_prod[25:13];
	wire [13:0] sum     = {2'b00, base} + {1'b0, ir_add};
	wire [11:0] limited = (sum > {2'b00, ceil_r}) ? ceil_r : sum[11:0];
	wire [11:0] out_nxt = (ceil_r <= mmc_pkg::CEIL_ZERO) ? 12'h000 : limited;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			out_voltage_r <= 12'h000;
		else
			out_voltage_r <= out_nxt;
	end

	assign link.d2h_byte  = d2h_byte_r;
	assign link.d2h_valid = d2h_vld_r;
endmodule : mmc_dev // mmc_dev

// ===== mmc_pkg.sv
// Purpose: Shared constants for the motor measurement and compensation register bank.
// Assumes: One clock, clk_sys at 100 MHz; bytes move over a parallel byte link.
// Notes:   Commands, widths and reset values are named here once.
package mmc_pkg;
	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [7:0] CMD_RD_SUPPLY  = 8'h10; // Supply voltage read.
	localparam logic [7:0] CMD_RD_SPEED   = 8'h11; // Speed input sample read.
	localparam logic [7:0] CMD_RD_CURRENT = 8'h12; // Load current read.
	localparam logic [7:0] CMD_RD_PERIOD  = 8'h14; // Input period read.
	localparam logic [7:0] CMD_RD_WIDTH   = 8'h15; // Input pulse width read.
	localparam logic [7:0] CMD_RD_IRCOMP  = 8'h20; // Resistance-drop comp read.
	localparam logic [7:0] CMD_RD_CEIL    = 8'h21; // Output ceiling read.
	localparam logic [7:0] CMD_RD_LOW     = 8'h22; // Speed input low level read.
	localparam logic [7:0] CMD_RD_HIGH    = 8'h23; // Speed input high level read.
	localparam logic [7:0] CMD_WR_IRCOMP  = 8'h60; // Resistance-drop comp write.
	localparam logic [7:0] CMD_WR_CEIL    = 8'h61; // Output ceiling write.
	localparam logic [7:0] CMD_WR_LOW     = 8'h62; // Speed input low level write.
	localparam logic [7:0] CMD_WR_HIGH    = 8'h63; // Speed input high level write.

	// ************************************************************
	// Field layout and widths
	// ************************************************************
	localparam int VAL_W     = 14; // Value carried per register.
	localparam int ADC_W     = 12; // Width of analog conversions.
	localparam int HI_LSB    = 7;  // Lowest value bit in the first data byte.
	localparam int OUT_W     = 12; // Width of the output voltage command.
	localparam logic [13:0] MEAS_MAX = 14'h3FFF; // Saturation point of measurements.

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [13:0] RST_IRCOMP = 14'h0000; // No compensation.
	localparam logic [11:0] RST_CEIL   = 12'hFFF;  // Ceiling wide open.
	localparam logic [11:0] RST_LOW    = 12'h000;  // Low level at zero.
	localparam logic [11:0] RST_HIGH   = 12'hFFF;  // High level at full scale.
	localparam logic [11:0] CEIL_ZERO  = 12'h003;  // Ceiling at or below this forces zero.

	// Device command parse states.
	typedef enum logic [1:0] {MMC_IDLE, MMC_HI, MMC_LO} mmc_dev_st_t;
endpackage : mmc_pkg

// ===== mmc_link_if.sv
`timescale 1ns/1ps
// Purpose: Byte link between the host end and the device end.
// Assumes: Both ends run on the same clk_sys.
// Notes:   A byte is taken in the cycle its valid is high.
interface mmc_link_if;
	logic [7:0] h2d_byte;  // Byte from host to device.
	logic       h2d_valid; // One-cycle strobe for h2d_byte.
	logic [7:0] d2h_byte;  // Byte from device to host.
	logic       d2h_valid; // One-cycle strobe for d2h_byte.

	modport dev  (input h2d_byte, input h2d_valid, output d2h_byte, output d2h_valid);
	modport host (output h2d_byte, output h2d_valid, input d2h_byte, input d2h_valid);
endinterface : mmc_link_if

// ===== mmc_pulse_meas.sv
`timescale 1ns/1ps
// Purpose: Measures period and high width of the PWM/brake input.
// Assumes: Input already synchronous to clk_sys.
// Notes:   Counts in clk_sys cycles, saturating at the 14-bit maximum.
module mmc_pulse_meas
(
	input  wire logic        clk_sys,     // System clock.
	input  wire logic        rstn,        // Asynchronous reset, active low.
	input  wire logic        pwm_in,      // PWM/brake input level.
	output logic      [13:0] period_r,    // Last full period.
	output logic      [13:0] width_r      // Last high pulse width.
);
	// ************************************************************
	// Edge detection and counters
	// ************************************************************
	logic        prev_r;   // Input level one cycle ago.
	logic [13:0] pcnt_r;   // Running period count.
	logic [13:0] wcnt_r;   // Running high count.
	wire         rise = pwm_in & ~prev_r; // Start of a period.
	wire         fall = ~pwm_in & prev_r; // End of the high pulse.
	// Saturating increments keep a stuck input from wrapping to small values.
	wire  [13:0] pcnt_inc = (pcnt_r == mmc_pkg::MEAS_MAX) ? pcnt_r : pcnt_r + 14'h0001;
	wire  [13:0] wcnt_inc = (wcnt_r == mmc_pkg::MEAS_MAX) ? wcnt_r : wcnt_r + 14'h0001;

	// Counts restart on each rising edge; a rise latches the period, a fall the width.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			prev_r   <= 1'b0;
			pcnt_r   <= 14'h0000;
			wcnt_r   <= 14'h0000;
			period_r <= 14'h0000;
			width_r  <= 14'h0000;
		end
		else
		begin
			prev_r <= pwm_in;
			pcnt_r <= rise ? 14'h0001 : pcnt_inc;
			wcnt_r <= rise ? 14'h0001 : (pwm_in ? wcnt_inc : wcnt_r);
			if (rise)
				period_r <= pcnt_r;
			if (fall)
				width_r <= wcnt_r;
		end
	end
endmodule : mmc_pulse_meas // mmc_pulse_meas

// ===== mmc_host.sv
`timescale 1ns/1ps
// Purpose: Host end: turns user requests into command bytes and rebuilds answers.
// Assumes: One request at a time; user waits for done.
// Notes:   Writes send three bytes, reads one and collect two.
module mmc_host
(
	input  wire logic        clk_sys,   // System clock.
	input  wire logic        rstn,      // Asynchronous reset, active low.
	mmc_link_if.host         link,      // Byte link to the device.
	input  wire logic        req,       // Pulse: start a transfer.
	input  wire logic [7:0]  req_cmd,   // Command code.
	input  wire logic [13:0] req_wdata, // Value to write.
	output logic             busy_r,    // Transfer in progress.
	output logic             done_r,    // Pulse: transfer finished.
	output logic      [13:0] rdata_r    // Value read back.
);
	logic [1:0]  left_r;  // Bytes still to send.
	logic [13:0] wd_r;    // Write value held.
	logic        rd_r;    // Waiting for an answer.
	logic        got_hi_r; // First answer byte seen.
	logic [7:0]  tx_r;    // Byte on the link.
	logic        tx_v_r;  // Strobe on the link.
	wire         is_rd = !req_cmd[6]; // Write commands sit at 60h and above.

	// Sends bytes back to back; answer bytes are caught as they come.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			rdata_r  <= 14'h0000;
			left_r   <= 2'h0;
			wd_r     <= 14'h0000;
			rd_r     <= 1'b0;
			got_hi_r <= 1'b0;
			tx_r     <= 8'h00;
			tx_v_r   <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			tx_v_r <= 1'b0;
			if (req && !busy_r)
			begin
				busy_r   <= 1'b1;
				tx_r     <= req_cmd;
				tx_v_r   <= 1'b1;
				wd_r     <= req_wdata;
				rd_r     <= is_rd;
				got_hi_r <= 1'b0;
				left_r   <= is_rd ? 2'h0 : 2'h2;
			end
			else if (left_r == 2'h2)
			begin
				tx_r   <= {1'b0, wd_r[13:7]};
				tx_v_r <= 1'b1;
				left_r <= 2'h1;
			end
			else if (left_r == 2'h1)
			begin
				tx_r   <= {1'b0, wd_r[6:0]};
				tx_v_r <= 1'b1;
				left_r <= 2'h0;
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end
			else if (rd_r && link.d2h_valid)
			begin
				if (!got_hi_r)
				begin
					rdata_r[13:7] <= link.d2h_byte[6:0];
					got_hi_r      <= 1'b1;
				end
				else
				begin
					rdata_r[6:0] <= link.d2h_byte[6:0];
					rd_r         <= 1'b0;
					busy_r       <= 1'b0;
					done_r       <= 1'b1;
				end
			end
		end
	end

	assign link.h2d_byte  = tx_r;
	assign link.h2d_valid = tx_v_r;
endmodule : mmc_host // mmc_host

// ===== mmc_link_sva.sv
`timescale 1ns/1ps
// Purpose: Watches the byte link between the host end and the device end.
// Assumes: One clock domain; a command byte with bit 6 set is followed by two data bytes.
// Notes:   Only link signals are visible here; values are judged by the bench.
module mmc_link_sva
(
	input  wire logic       clk_sys,   // System clock.
	input  wire logic       rstn,      // Asynchronous reset, active low.
	input  wire logic [7:0] h2d_byte,  // Byte from host to device.
	input  wire logic       h2d_valid, // Strobe for h2d_byte.
	input  wire logic [7:0] d2h_byte,  // Byte from device to host.
	input  wire logic       d2h_valid  // Strobe for d2h_byte.
);
	// ************************************************************
	// Command tracking
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	logic [1:0] data_left_r;   // Write data bytes still due after a command.
	logic [1:0] data_left_nxt; // Next value of the count above.
	// A byte is a command only when no write data is still owed.
	wire logic cmd_seen = h2d_valid && (data_left_r == 2'h0);
	wire logic cmd_wr   = cmd_seen && h2d_byte[6];
	// Reads of twelve-bit registers leave value bits 13 and 12 clear.
	wire logic cmd_12b  = cmd_seen && (h2d_byte == mmc_pkg::CMD_RD_SUPPLY
		|| h2d_byte == mmc_pkg::CMD_RD_SPEED || h2d_byte == mmc_pkg::CMD_RD_CURRENT
		|| h2d_byte == mmc_pkg::CMD_RD_CEIL || h2d_byte == mmc_pkg::CMD_RD_LOW
		|| h2d_byte == mmc_pkg::CMD_RD_HIGH);
	wire logic cmd_14b  = cmd_seen && (h2d_byte == mmc_pkg::CMD_RD_PERIOD
		|| h2d_byte == mmc_pkg::CMD_RD_WIDTH || h2d_byte == mmc_pkg::CMD_RD_IRCOMP);
	wire logic cmd_rd   = cmd_12b || cmd_14b;
	wire logic data_byte = h2d_valid && (data_left_r != 2'h0);

	assign data_left_nxt = cmd_wr ? 2'h2 : (data_byte ? data_left_r - 2'h1 : data_left_r);

	// The count restarts with reset so a half-sent write never skews later decoding.
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			data_left_r <= 2'h0;
		else
			data_left_r <= data_left_nxt;

	// ************************************************************
	// Link properties
	// ************************************************************
	a_read_answer_pair: assert property (cmd_rd |=> d2h_valid ##1 d2h_valid ##1 !d2h_valid)
		else $error("read command not answered by exactly two bytes");
	a_reply_top_clear: assert property (d2h_valid |-> !d2h_byte[7])
		else $error("device byte has its top bit set");
	a_host_top_clear: assert property (data_byte |-> !h2d_byte[7])
		else $error("host data byte has its top bit set");
	a_narrow_hi_zero: assert property (cmd_12b |=> d2h_byte[6:5] == 2'h0)
		else $error("twelve-bit value carries bits above bit 11");
	a_write_no_reply: assert property (cmd_wr |=> !d2h_valid [*4])
		else $error("device answered a write command");
	a_write_bytes_follow: assert property (cmd_wr |=> h2d_valid ##1 h2d_valid ##1 !h2d_valid)
		else $error("write command not followed by two data bytes");
	a_answer_has_cause: assert property ($rose(d2h_valid) |-> $past(cmd_rd))
		else $error("device answer without a read command");
	a_cmd_link_quiet: assert property (cmd_seen |-> !d2h_valid)
		else $error("command sent while device still answering");

	c_read_seen: cover property (cmd_rd ##1 d2h_valid);
	c_write_seen: cover property (cmd_wr ##3 !d2h_valid);
	c_saturated_low: cover property (cmd_14b ##2 (d2h_byte == 8'h7F));
endmodule : mmc_link_sva

// ===== test_motor_measure_comp_regs.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench for host and device ends joined by the byte link.
// Assumes: Mode switches stay off, so speed levels come from the values held at reset.
// Notes:   Random values come from a fixed-seed xorshift, so every run is the same.
module test_motor_measure_comp_regs;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic        clk_sys, rstn, req, busy_r, done_r;           // Clock, reset, host handshake.
	logic [7:0]  req_cmd;                                      // Host command code.
	logic [13:0] req_wdata, rdata_r;                           // Host write and read values.
	logic [11:0] supply_adc, speed_adc, current_adc, speed_reg; // Device level inputs.
	logic [11:0] pot_ceiling, out_voltage_r;                   // Potentiometer and output.
	logic        pwm_in, pot_moved, speed_lock_bit, ceil_lock, supply_comp_en;
	logic        mode_sw1, mode_sw2;                           // Held off for the whole run.
	logic [31:0] seed, v;                                      // Generator state and draw.
	logic [11:0] ceils [4];                                    // Ceiling corner table.
	int          failures, num_checks;                         // Mismatch and compare counts.

	mmc_link_if mmc_link_if_i();
	mmc_host mmc_host_i (.clk_sys, .rstn, .link(mmc_link_if_i.host), .req, .req_cmd, .req_wdata,
		.busy_r, .done_r, .rdata_r);
	mmc_dev mmc_dev_i (.clk_sys, .rstn, .link(mmc_link_if_i.dev), .supply_adc, .speed_adc,
		.current_adc, .pwm_in, .speed_reg, .pot_ceiling, .pot_moved, .speed_lock_bit,
		.ceil_lock, .supply_comp_en, .mode_sw1, .mode_sw2, .out_voltage_r);
	mmc_link_sva mmc_link_sva_i (.clk_sys(clk_sys), .rstn(rstn),
		.h2d_byte(mmc_link_if_i.h2d_byte), .h2d_valid(mmc_link_if_i.h2d_valid),
		.d2h_byte(mmc_link_if_i.d2h_byte), .d2h_valid(mmc_link_if_i.d2h_valid));

	// ************************************************************
	// Helpers
	// ************************************************************
	// Xorshift draw; repeatable because the seed is fixed at time zero.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected output for a demand under a ceiling; a ceiling of three or less means zero.
	function automatic logic [13:0] clamp(input logic [11:0] dem, input logic [11:0] ceil);
		if (ceil <= 12'h003)
			return 14'h0000;
		return {2'h0, (dem > ceil) ? ceil : dem};
	endfunction

	// Compare and count; an unknown never passes for a match.
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One host request; waits for done under a bound so a lost answer cannot hang.
	task automatic xfer(input logic [7:0] cmd, input logic [13:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= 1'b1;
		req_cmd <= cmd;
		req_wdata <= wd;
		@(posedge clk_sys);
		req <= 1'b0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while (done_r !== 1'b1 && n < 40);
		if (n >= 40)
			chk(14'h3FFF, 14'h0000);
		// The host must be free again in the cycle that it reports done.
		chk({13'h0000, busy_r}, 14'h0000);
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [13:0] exp);
		xfer(cmd, 14'h0000);
		chk(rdata_r, exp);
	endtask

	// Output is registered every cycle; a few cycles let the arithmetic settle.
	task automatic outchk(input logic [13:0] exp);
		repeat (4) @(negedge clk_sys);
		chk({2'h0, out_voltage_r}, exp);
	endtask

	// High for h cycles, then low for l cycles.
	task automatic pulse(input int h, input int l);
		@(posedge clk_sys);
		pwm_in <= 1'b1;
		repeat (h) @(posedge clk_sys);
		pwm_in <= 1'b0;
		repeat (l - 1) @(posedge clk_sys);
	endtask

	task automatic test_done();
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// The run needs about 20000 cycles; three times that means a hang.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		failures++;
		test_done();
	end

	initial
	begin
		{rstn, req, pwm_in, pot_moved, speed_lock_bit, ceil_lock, supply_comp_en} = 7'h00;
		{mode_sw1, mode_sw2, req_cmd, req_wdata} = 24'h000000;
		{supply_adc, speed_adc, current_adc, speed_reg, pot_ceiling} = 60'h0;
		{failures, num_checks, seed} = {32'h0, 32'h0, 32'h0000459E};
		ceils = '{12'h000, 12'h003, 12'h004, 12'h100};
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(mmc_pkg::CMD_RD_IRCOMP, 14'h0000);
		rd(mmc_pkg::CMD_RD_CEIL, 14'h0FFF);
		rd(mmc_pkg::CMD_RD_LOW, 14'h0000);
		rd(mmc_pkg::CMD_RD_HIGH, 14'h0FFF);
		// Corner draws first: all ones, then all zeros, then random.
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h00000000 : rnd());
			@(posedge clk_sys);
			supply_adc <= v[11:0];
			speed_adc <= v[23:12];
			current_adc <= {v[31:24], v[3:0]};
			rd(mmc_pkg::CMD_RD_SUPPLY, {2'h0, v[11:0]});
			rd(mmc_pkg::CMD_RD_SPEED, {2'h0, v[23:12]});
			rd(mmc_pkg::CMD_RD_CURRENT, {2'h0, v[31:24], v[3:0]});
			xfer(mmc_pkg::CMD_WR_IRCOMP, v[13:0]);
			rd(mmc_pkg::CMD_RD_IRCOMP, v[13:0]);
			xfer(mmc_pkg::CMD_WR_LOW, {2'h0, v[27:16]});
			rd(mmc_pkg::CMD_RD_LOW, {2'h0, v[27:16]});
			xfer(mmc_pkg::CMD_WR_HIGH, {2'h0, v[31:20]});
			rd(mmc_pkg::CMD_RD_HIGH, {2'h0, v[31:20]});
			xfer(mmc_pkg::CMD_WR_CEIL, {2'h0, v[19:8]});
			rd(mmc_pkg::CMD_RD_CEIL, {2'h0, v[19:8]});
		end
		// Newly written levels must not steer the output before a restart.
		xfer(mmc_pkg::CMD_WR_CEIL, 14'h0FFF);
		xfer(mmc_pkg::CMD_WR_IRCOMP, 14'h0000);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk_sys);
			speed_adc <= (i == 0) ? 12'h000 : ((i == 1) ? 12'h400 : 12'hFFF);
			outchk((i == 0) ? 14'h0000 : ((i == 1) ? 14'h0400 : 14'h0FFF));
		end
		// With the lock set, the serial speed value steers the output.
		@(posedge clk_sys);
		speed_lock_bit <= 1'b1;
		speed_reg <= 12'h123;
		speed_adc <= 12'hABC;
		outchk(14'h0123);
		@(posedge clk_sys);
		speed_reg <= 12'h800;
		foreach (ceils[k])
		begin
			xfer(mmc_pkg::CMD_WR_CEIL, {2'h0, ceils[k]});
			outchk(clamp(12'h800, ceils[k]));
		end
		// Supply compensation scales demand by the ceiling only when enabled.
		xfer(mmc_pkg::CMD_WR_CEIL, 14'h0800);
		@(posedge clk_sys);
		speed_reg <= 12'h400;
		supply_comp_en <= 1'b1;
		outchk(14'h0200);
		@(posedge clk_sys);
		supply_comp_en <= 1'b0;
		outchk(14'h0400);
		// Load current times compensation adds to the demand.
		xfer(mmc_pkg::CMD_WR_CEIL, 14'h0FFF);
		xfer(mmc_pkg::CMD_WR_IRCOMP, 14'h2000);
		@(posedge clk_sys);
		speed_reg <= 12'h100;
		current_adc <= 12'h400;
		outchk(14'h0500);
		// A locked ceiling ignores the potentiometer; unlocked it follows.
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_sys);
			ceil_lock <= (i == 0);
			pot_ceiling <= 12'h050;
			pot_moved <= 1'b1;
			@(posedge clk_sys);
			pot_moved <= 1'b0;
			rd(mmc_pkg::CMD_RD_CEIL, (i == 0) ? 14'h0FFF : 14'h0050);
		end
		// An unknown write code changes nothing.
		xfer(8'h6F, 14'h0005);
		rd(mmc_pkg::CMD_RD_CEIL, 14'h0050);
		// Period and width in cycles, then a long low time that must saturate.
		repeat (3) pulse(7, 13);
		rd(mmc_pkg::CMD_RD_PERIOD, 14'h0014);
		rd(mmc_pkg::CMD_RD_WIDTH, 14'h0007);
		pulse(5, 17000);
		pulse(5, 10);
		rd(mmc_pkg::CMD_RD_PERIOD, 14'h3FFF);
		rd(mmc_pkg::CMD_RD_WIDTH, 14'h0005);
		test_done();
	end
endmodule : test_motor_measure_comp_regs
